// ==== hw/eia_core.sv ====
// Exception and interrupt acceptance at retirement boundaries
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// What this block does
// - Exceptions except aborts and all interrupts taken only at boundaries.
// - Faults save the faulting address and request rollback of registers.
// - Traps save next address, the transfer target when control moved.
// - Aborts are flagged not restartable; their saved pointer is unreliable.
// - Interrupts save the next address at the accepting boundary.
// - Repeated instructions accept interrupts per iteration, resuming same one.
// - Only in-order retirement events can raise or take anything.
// - Nonmaskable pin or message dispatches to vector 2 at the next boundary.
// - Nonmaskable requests and exceptions ignore the interrupt-enable flag.
// - Maskable vector 2 runs that handler without nonmaskable blocking.
// - After nonmaskable dispatch, block more until interrupt return retires.
// - Interrupt return faulting in low-privilege v86 still clears the block.
// - Enable flag clear stops pin and local unit maskable requests.
// - Hardware reset clears the interrupt-enable flag.
// - Pin takes any vector, local unit 16 up; no error code pushed.
// - Set and clear enable need privilege within I/O level, else fault.
// - Task switch, pop flags, interrupt return reload the enable flag.
// - Interrupt gate entry clears enable flag; trap gate leaves it.
// - Resume flag set suppresses instruction-breakpoint debug exceptions.
// - Software interrupt to an exception vector pushes no error code.
module eia_core
  import eia_pkg::*;
(
  input  wire  logic        sys_clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        ce_i,
  input  wire  eia_retire_t ret_i,
  input  wire  eia_gate_t   gate_i,
  input  wire  logic        nmi_pin_i,
  input  wire  logic        mreq_pin_i,
  input  wire  logic [7:0]  mreq_vec_i,
  input  wire  logic        lint_req_i,
  input  wire  logic [7:0]  lint_vec_i,
  input  wire  logic        lint_nmi_i,
  input  wire  logic        hsel_i,
  input  wire  logic [31:0] haddr_i,
  input  wire  logic [1:0]  htrans_i,
  input  wire  logic        hwrite_i,
  input  wire  logic [2:0]  hsize_i,
  input  wire  logic [31:0] hwdata_i,
  input  wire  logic        hready_i,
  output logic              take_o,
  output logic [7:0]        take_vec_o,
  output logic [31:0]       ret_ip_o,
  output logic              push_err_o,
  output logic              rollback_o,
  output logic              restartable_o,
  output logic              is_nmi_o,
  output logic              is_ext_o,
  output logic              if_o,
  output logic              rf_o,
  output logic              nmi_blk_o,
  output logic              mreq_ack_o,
  output logic              lint_ack_o,
  output logic              lint_bad_o,
  output logic              hreadyout_o,
  output logic              hresp_o,
  output logic [31:0]       hrdata_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic       mreq_s1_q, mreq_s2_q;
  logic [7:0] mvec_s1_q, mvec_s2_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nmi_s1_q  <= 1'b0;
      nmi_s2_q  <= 1'b0;
      nmi_s3_q  <= 1'b0;
      mreq_s1_q <= 1'b0;
      mreq_s2_q <= 1'b0;
      mvec_s1_q <= 8'h00;
      mvec_s2_q <= 8'h00;
    end else if (ce_i) begin
      nmi_s1_q  <= nmi_pin_i;
      nmi_s2_q  <= nmi_s1_q;
      nmi_s3_q  <= nmi_s2_q;
      mreq_s1_q <= mreq_pin_i;
      mreq_s2_q <= mreq_s1_q;
      mvec_s1_q <= mreq_vec_i;
      mvec_s2_q <= mvec_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        if_q, if_d, rf_q, rf_d;
  logic        nmi_pend_q, nmi_pend_d, nmi_blk_q, nmi_blk_d;
  logic [1:0]  hold_q, hold_d;
  logic [31:0] ctrl_q, ctrl_d, last_ip_q;
  logic [7:0]  last_vec_q;

  // ----------------------------------------------------------------
  // Boundary decode
  // ----------------------------------------------------------------
  // retirement only
  wire bnd      = ce_i & ret_i.valid;
  wire priv_ok  = ret_i.current_privilege_level <= ret_i.io_privilege_level;
  wire if_gp    = (ret_i.set_enable_instr | ret_i.clear_enable_instr) & ~priv_ok;
  wire interrupt_return_instr_gp  = ret_i.interrupt_return_instr & ret_i.vm86 & (ret_i.io_privilege_level != IO_PRIVILEGE_LEVEL_MAX);
  wire gp_hit   = if_gp | interrupt_return_instr_gp;
  wire dbg_hit  = ret_i.ibp_match & ~rf_q & ctrl_q[CTRL_IBP_EN];
  wire sel_ab   = ret_i.abort;
  wire sel_ft   = ~sel_ab & ret_i.fault;
  wire sel_gp   = ~sel_ab & ~ret_i.fault & gp_hit;
  wire sel_db   = ~sel_ab & ~ret_i.fault & ~gp_hit & dbg_hit;
  wire flt_any  = sel_ft | sel_gp | sel_db;
  wire exec_ok  = ~sel_ab & ~flt_any;
  wire sel_tr   = exec_ok & ret_i.trap;
  wire sel_sw   = exec_ok & ~ret_i.trap & ret_i.swint;
  wire exc_any  = sel_ab | flt_any | sel_tr | sel_sw;
  wire irq_ok   = bnd & ~exc_any;
  wire fl_load  = exec_ok & (ret_i.pop_flags_instr | ret_i.interrupt_return_instr | ret_i.tswitch);

  wire [31:0] seq_ip = ret_i.rep_more ? ret_i.ip : ret_i.next_ip;

  // Flag value after this instruction, used to gate its boundary
  // flags reload
  wire if_exec  = fl_load ? ret_i.flags_ld[FLAG_IF_BIT] :
                  (exec_ok & ret_i.set_enable_instr) ? 1'b1 :
                  (exec_ok & ret_i.clear_enable_instr) ? 1'b0 : if_q;
  wire if_next  = ret_i.valid ? if_exec : if_q;

  wire nmi_clr  = bnd & ret_i.interrupt_return_instr & (exec_ok | (sel_gp & interrupt_return_instr_gp));
  wire nmi_edge = nmi_s2_q & ~nmi_s3_q;

  wire nmi_take = irq_ok & nmi_pend_q & (~nmi_blk_q | nmi_clr);
  wire pin_take = irq_ok & ~nmi_take & if_next & mreq_s2_q &
                  (hold_q == 2'h0);
  wire lint_ok  = lint_vec_i >= LINT_VEC_MIN;
  wire lint_take = irq_ok & ~nmi_take & ~pin_take & if_next &
                   lint_req_i & lint_ok & ~lint_ack_o;
  wire ext_take = pin_take | lint_take;
  wire take_d   = (bnd & exc_any) | nmi_take | ext_take;

  // ----------------------------------------------------------------
  // Dispatch selection
  // ----------------------------------------------------------------
  wire [7:0] vec_d = (sel_ab | sel_ft | sel_tr) ? ret_i.exc_vec :
                     sel_gp    ? VEC_GP :
                     sel_db    ? VEC_DB :
                     sel_sw    ? ret_i.sw_vec :
                     nmi_take  ? VEC_NMI :
                     pin_take  ? mvec_s2_q : lint_vec_i;

  // trap points past, or to target
  wire [31:0] ip_d = (sel_ab | flt_any) ? ret_i.ip : seq_ip;

  wire err_d = sel_gp | ((sel_ab | sel_ft | sel_tr) & ret_i.exc_err);

  // ----------------------------------------------------------------
  // Flag and blocking next state
  // ----------------------------------------------------------------
  // interrupt gate clears flag
  assign if_d = (gate_i.valid & ~gate_i.trap_gate) ? 1'b0 : if_next;
  assign rf_d = ~ret_i.valid ? rf_q :
                fl_load ? ret_i.flags_ld[FLAG_RF_BIT] :
                exec_ok ? 1'b0 : rf_q;

  assign nmi_blk_d  = nmi_take | (nmi_blk_q & ~nmi_clr);
  assign nmi_pend_d = nmi_edge | lint_nmi_i | (nmi_pend_q & ~nmi_take);
  assign hold_d     = pin_take ? PIN_HOLDOFF :
                      (hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      if_q       <= 1'b0;
      rf_q       <= 1'b0;
      nmi_blk_q  <= 1'b0;
      nmi_pend_q <= 1'b0;
      hold_q     <= 2'h0;
    end else if (ce_i) begin
      if_q       <= if_d;
      rf_q       <= rf_d;
      nmi_blk_q  <= nmi_blk_d;
      nmi_pend_q <= nmi_pend_d;
      hold_q     <= hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Dispatch outputs
  // ----------------------------------------------------------------
  // report at boundary
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      take_o        <= 1'b0;
      take_vec_o    <= 8'h00;
      ret_ip_o      <= 32'h0000_0000;
      push_err_o    <= 1'b0;
      rollback_o    <= 1'b0;
      restartable_o <= 1'b0;
      is_nmi_o      <= 1'b0;
      is_ext_o      <= 1'b0;
      mreq_ack_o    <= 1'b0;
      lint_ack_o    <= 1'b0;
      lint_bad_o    <= 1'b0;
      last_ip_q     <= 32'h0000_0000;
      last_vec_q    <= 8'h00;
    end else if (ce_i) begin
      take_o        <= take_d;
      take_vec_o    <= vec_d;
      ret_ip_o      <= ip_d;
      push_err_o    <= take_d & err_d;
      rollback_o    <= bnd & flt_any;
      restartable_o <= take_d & ~sel_ab;
      is_nmi_o      <= nmi_take;
      is_ext_o      <= ext_take;
      mreq_ack_o    <= pin_take;
      lint_ack_o    <= lint_take;
      lint_bad_o    <= lint_req_i & ~lint_ok & ~lint_bad_o;
      if (take_d) begin
        last_ip_q  <= ip_d;
        last_vec_q <= vec_d;
      end
    end
  end

  assign if_o      = if_q;
  assign rf_o      = rf_q;
  assign nmi_blk_o = nmi_blk_q;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic       wr_q;
  logic [7:0] waddr_q;
  wire        acc   = hsel_i & htrans_i[1] & hready_i;
  wire [7:0]  aoff  = haddr_i[7:0];
  wire        hit   = haddr_i[31:8] == 24'h00_0000;
  wire        wr_ct = wr_q & (waddr_q == OFF_CTRL);

  assign ctrl_d = wr_ct ? {31'h0000_0000, hwdata_i[CTRL_IBP_EN]} : ctrl_q;

  wire [31:0] status = {16'h0000, last_vec_q, 4'h0, nmi_pend_q,
                        nmi_blk_q, rf_q, if_q};
  wire [31:0] rd_d   = ~hit                 ? 32'h0000_0000 :
                       (aoff == OFF_CTRL)    ? ctrl_d :
                       (aoff == OFF_STATUS)  ? status :
                       (aoff == OFF_LAST_IP) ? last_ip_q : 32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_q        <= 1'b0;
      waddr_q     <= 8'h00;
      ctrl_q      <= CTRL_RST;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (ce_i) begin
      wr_q     <= acc & hwrite_i & hit;
      waddr_q  <= aoff;
      ctrl_q   <= ctrl_d;
      if (acc & ~hwrite_i) begin
        hrdata_o <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_boundary;
    $past(ce_i) && take_o |-> $past(ret_i.valid);
  endproperty
  a_boundary: assert property (p_boundary) else $error("take off boundary");

  property p_fault_ip;
    $past(ce_i) && rollback_o |-> take_o && ret_ip_o == $past(ret_i.ip);
  endproperty
  a_fault_ip: assert property (p_fault_ip) else $error("fault ip wrong");

  property p_trap_ip;
    $past(bnd && sel_tr) |-> take_o && ret_ip_o == $past(seq_ip) && !rollback_o;
  endproperty
  a_trap_ip: assert property (p_trap_ip) else $error("trap ip wrong");

  property p_nmi_vec;
    take_o && is_nmi_o |-> take_vec_o == VEC_NMI && nmi_blk_o && !push_err_o;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");

  property p_nmi_once;
    $past(ce_i) && take_o && is_nmi_o |-> !$past(nmi_blk_q) || $past(nmi_clr);
  endproperty
  a_nmi_once: assert property (p_nmi_once) else $error("nmi while blocked");

  property p_if_mask;
    $past(ce_i) && is_ext_o |-> $past(if_next) && take_o;
  endproperty
  a_if_mask: assert property (p_if_mask) else $error("masked irq taken");

  property p_if_reset;
    $past(rst_i) |-> !if_o && !nmi_blk_o;
  endproperty
  a_if_reset: assert property (p_if_reset) else $error("reset flags wrong");

  property p_lint_range;
    lint_ack_o |-> take_vec_o >= LINT_VEC_MIN && !push_err_o;
  endproperty
  a_lint_range: assert property (p_lint_range) else $error("bad lint vec");

  property p_priv;
    $past(bnd && if_gp && !ret_i.abort && !ret_i.fault) |->
      take_o && take_vec_o == VEC_GP && if_o == $past(if_q);
  endproperty
  a_priv: assert property (p_priv) else $error("privilege miss");

  property p_gate;
    $past(ce_i && gate_i.valid && !gate_i.trap_gate) |-> !if_o;
  endproperty
  a_gate: assert property (p_gate) else $error("gate left flag");

  property p_swint;
    $past(bnd && sel_sw) |-> take_o && !push_err_o;
  endproperty
  a_swint: assert property (p_swint) else $error("sw int pushed code");

  property p_abort;
    $past(bnd && ret_i.abort) |-> take_o && !restartable_o && !rollback_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort marked restartable");

  property p_irq_ip;
    $past(ce_i && !ret_i.rep_more) && (is_ext_o || is_nmi_o) |->
      ret_ip_o == $past(ret_i.next_ip) && !push_err_o;
  endproperty
  a_irq_ip: assert property (p_irq_ip) else $error("irq ip wrong");

  property p_rep_ip;
    $past(ce_i && ret_i.rep_more) && (is_ext_o || is_nmi_o) |-> ret_ip_o == $past(ret_i.ip);
  endproperty
  a_rep_ip: assert property (p_rep_ip) else $error("repeat ip wrong");

  property p_nmi_unmasked;
    $past(bnd && nmi_pend_q && !nmi_blk_q && !exc_any) |-> take_o && is_nmi_o;
  endproperty
  a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("nmi not taken");

  property p_ext_noblk;
    $past(ce_i) && is_ext_o |-> !is_nmi_o && (!nmi_blk_o || $past(nmi_blk_q));
  endproperty
  a_ext_noblk: assert property (p_ext_noblk) else $error("maskable set nmi block");

  property p_v86_interrupt_return_instr;
    $past(bnd && ret_i.interrupt_return_instr && ret_i.vm86 && (ret_i.io_privilege_level != IO_PRIVILEGE_LEVEL_MAX) &&
          !ret_i.abort && !ret_i.fault) |-> take_o && take_vec_o == VEC_GP && !nmi_blk_o;
  endproperty
  a_v86_interrupt_return_instr: assert property (p_v86_interrupt_return_instr) else $error("v86 return kept block");

  property p_flag_load;
    $past(bnd && (ret_i.pop_flags_instr || ret_i.interrupt_return_instr || ret_i.tswitch) && !exc_any && !gate_i.valid) |->
      if_o == $past(ret_i.flags_ld[FLAG_IF_BIT]);
  endproperty
  a_flag_load: assert property (p_flag_load) else $error("flag load missed");

  property p_rf_mask;
    $past(bnd && ret_i.ibp_match && rf_q && !ret_i.fault && !gp_hit) |-> !rollback_o;
  endproperty
  a_rf_mask: assert property (p_rf_mask) else $error("resume flag ignored");

endmodule

// ==== hw/eia_pkg.sv ====
// Constants and types for the exception and interrupt acceptance unit
package eia_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_LAST_IP = 8'h08;
  localparam int          CTRL_IBP_EN = 0;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
  localparam int          ST_IF       = 0;
  localparam int          ST_RF       = 1;
  localparam int          ST_NMI_BLK  = 2;
  localparam int          ST_NMI_PEND = 3;
  localparam int          ST_VEC_LSB  = 8;

  // ----------------------------------------------------------------
  // Flags and vectors
  // ----------------------------------------------------------------
  localparam int         FLAG_IF_BIT  = 9;
  localparam int         FLAG_RF_BIT  = 16;
  localparam logic [7:0] VEC_DB       = 8'h01;
  localparam logic [7:0] VEC_NMI      = 8'h02;
  localparam logic [7:0] VEC_GP       = 8'h0D;
  localparam logic [7:0] LINT_VEC_MIN = 8'h10;
  localparam logic [1:0] IO_PRIVILEGE_LEVEL_MAX     = 2'h3;

  // ----------------------------------------------------------------
  // Timing and bus transfer type
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_HOLDOFF  = 2'h3;
  localparam logic [1:0] HTRANS_NSEQ  = 2'h2;

  // One retiring instruction, in program order
  typedef struct packed {
    logic        valid;
    logic [31:0] ip;
    logic [31:0] next_ip;
    logic        rep_more;
    logic        fault;
    logic        trap;
    logic        abort;
    logic [7:0]  exc_vec;
    logic        exc_err;
    logic        swint;
    logic [7:0]  sw_vec;
    logic        set_enable_instr;
    logic        clear_enable_instr;
    logic        pop_flags_instr;
    logic        interrupt_return_instr;
    logic        tswitch;
    logic [31:0] flags_ld;
    logic        ibp_match;
    logic [1:0]  current_privilege_level;
    logic [1:0]  io_privilege_level;
    logic        vm86;
  } eia_retire_t;

  // Gate type seen when the handler is entered
  typedef struct packed {
    logic valid;
    logic trap_gate;
  } eia_gate_t;

endpackage

// ==== hw/eia_placeholder_none.sv ====
// Intentionally empty file kept out

// ==== tb/eia_irq_model.sv ====
// Far-side model: external interrupt controller and local interrupt unit
`timescale 1ns/1ps
module eia_irq_model
  import eia_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] go_i,
  input  wire logic [7:0] vec_i,
  input  wire logic       mreq_ack_i,
  input  wire logic       lint_ack_i,
  input  wire logic       lint_bad_i,
  output logic            mreq_pin_o,
  output logic [7:0]      mreq_vec_o,
  output logic            lint_req_o,
  output logic [7:0]      lint_vec_o,
  output logic            nmi_pin_o,
  output logic            lint_nmi_o
);
  logic [7:0] pin_vec_q;
  logic [7:0] lint_vec_q;
  logic [2:0] nmi_sr_q;

  // ----------------------------------------------------------------
  // Maskable requests held until acknowledged or refused; nonmaskable ones only pulsed
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mreq_pin_o <= 1'b0;
      lint_req_o <= 1'b0;
      lint_nmi_o <= 1'b0;
      nmi_sr_q   <= 3'h0;
    end else begin
      mreq_pin_o <= go_i[0] | (mreq_pin_o & ~mreq_ack_i);
      lint_req_o <= go_i[1] | (lint_req_o & ~lint_ack_i & ~lint_bad_i);
      lint_nmi_o <= go_i[3];
      nmi_sr_q   <= {nmi_sr_q[1:0], go_i[2]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (go_i[0]) begin
      pin_vec_q <= vec_i;
    end
    if (go_i[1]) begin
      lint_vec_q <= vec_i;
    end
  end

  // Released vector lines show the inverse of the last value
  assign mreq_vec_o = mreq_pin_o ? pin_vec_q : ~pin_vec_q;
  assign lint_vec_o = lint_req_o ? lint_vec_q : ~lint_vec_q;
  assign nmi_pin_o  = |nmi_sr_q;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the exception and interrupt acceptance unit
`timescale 1ns/1ps
module tb_top
  import eia_pkg::*;
();
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        ce        = 1'b1;
  eia_retire_t ret       = '0;
  eia_gate_t   gate      = '0;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [3:0]  go        = 4'h0;
  logic [7:0]  gvec      = 8'h00;
  eia_retire_t r;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          n_bad      = 0;
  logic        nmi_pin, mreq_pin, lint_req, lint_nmi, take_o, push_err_o, rollback_o;
  logic        restartable_o, is_nmi_o, is_ext_o, if_o, rf_o, nmi_blk_o, mreq_ack_o;
  logic        lint_ack_o, lint_bad_o, hreadyout_o, hresp_o;
  logic [7:0]  mreq_vec, lint_vec, take_vec_o;
  logic [31:0] ret_ip_o, hrdata_o;

  always #50 sys_clk_i = ~sys_clk_i;

  eia_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .ret_i(ret), .gate_i(gate),
    .nmi_pin_i(nmi_pin), .mreq_pin_i(mreq_pin), .mreq_vec_i(mreq_vec), .lint_req_i(lint_req),
    .lint_vec_i(lint_vec), .lint_nmi_i(lint_nmi), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout_o), .take_o(take_o), .take_vec_o(take_vec_o), .ret_ip_o(ret_ip_o),
    .push_err_o(push_err_o), .rollback_o(rollback_o), .restartable_o(restartable_o),
    .is_nmi_o(is_nmi_o), .is_ext_o(is_ext_o), .if_o(if_o), .rf_o(rf_o),
    .nmi_blk_o(nmi_blk_o), .mreq_ack_o(mreq_ack_o), .lint_ack_o(lint_ack_o),
    .lint_bad_o(lint_bad_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o));

  eia_irq_model u_src (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go), .vec_i(gvec),
    .mreq_ack_i(mreq_ack_o), .lint_ack_i(lint_ack_o), .lint_bad_i(lint_bad_o),
    .mreq_pin_o(mreq_pin), .mreq_vec_o(mreq_vec), .lint_req_o(lint_req),
    .lint_vec_o(lint_vec), .nmi_pin_o(nmi_pin), .lint_nmi_o(lint_nmi));

  always @(posedge sys_clk_i) if (lint_bad_o === 1'b1) n_bad++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task print_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wait_rdy;
    for (int i = 0; i <= 20; i++) begin
      @(posedge sys_clk_i);
      if (hreadyout_o === 1'b1) break;
      if (i == 20) begin
        n_mismatch++;
        print_verdict;
      end
    end
  endtask

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr  <= a;
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata_o;
  endtask

  function automatic eia_retire_t base(input logic [31:0] ip);
    eia_retire_t b;
    b = '0;
    b.valid = 1'b1;
    b.ip = ip;
    b.next_ip = ip + 32'h0000_0004;
    return b;
  endfunction

  // One retire; a zero ip skips the saved-pointer compare
  task rt(input eia_retire_t x, input logic t, input logic [7:0] v, input logic [31:0] ip);
    @(posedge sys_clk_i);
    ret <= x;
    @(posedge sys_clk_i);
    ret.valid <= 1'b0;
    #1;
    chk(take_o, t);
    if (t && ip != 32'h0000_0000) chk(ret_ip_o, ip);
    if (t) chk(take_vec_o, v);
  endtask

  task gt(input logic tg);
    @(posedge sys_clk_i);
    gate <= {1'b1, tg};
    @(posedge sys_clk_i);
    gate.valid <= 1'b0;
    #1;
  endtask

  task src(input int k, input logic [7:0] v);
    @(posedge sys_clk_i);
    go   <= 4'h1 << k;
    gvec <= v;
    @(posedge sys_clk_i);
    go   <= 4'h0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk(if_o, 1'b0);
    chk(nmi_blk_o, 1'b0);
    ahb(1'b0, OFF_CTRL, 32'h0000_0000); chk(rd, CTRL_RST);
    ahb(1'b0, OFF_STATUS, 32'h0000_0000); chk(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_000C, 32'h0000_0000); chk(rd, 32'h0000_0000);
    r = base(32'h0000_0100); r.fault = 1'b1; r.exc_vec = 8'h0E; r.exc_err = 1'b1;
    rt(r, 1'b1, 8'h0E, 32'h0000_0100);
    chk({rollback_o, restartable_o, push_err_o}, 3'h7);
    r = base(32'h0000_0200); r.trap = 1'b1; r.exc_vec = 8'h04; r.next_ip = 32'h0000_2000;
    rt(r, 1'b1, 8'h04, 32'h0000_2000);
    chk(rollback_o, 1'b0);
    r = base(32'h0000_0300); r.abort = 1'b1; r.exc_vec = 8'h08;
    rt(r, 1'b1, 8'h08, 32'h0000_0000);
    chk(restartable_o, 1'b0);
    r = base(32'h0000_0400); r.valid = 1'b0; r.fault = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000);
    r = base(32'h0000_0500); r.swint = 1'b1; r.sw_vec = VEC_GP;
    rt(r, 1'b1, VEC_GP, 32'h0000_0504);
    chk(push_err_o, 1'b0);
    r = base(32'h0000_0600); r.ibp_match = 1'b1;
    rt(r, 1'b1, VEC_DB, 32'h0000_0000);
    r = base(32'h0000_0610); r.pop_flags_instr = 1'b1; r.flags_ld[FLAG_RF_BIT] = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(rf_o, 1'b1);
    r = base(32'h0000_0620); r.ibp_match = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000);
    ahb(1'b1, OFF_CTRL, 32'h0000_0000);
    ahb(1'b0, OFF_CTRL, 32'h0000_0000); chk(rd, 32'h0000_0000);
    r = base(32'h0000_0630); r.ibp_match = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000);
    src(0, 8'h0E);
    rt(base(32'h0000_0700), 1'b0, 8'h00, 32'h0000_0000);
    r = base(32'h0000_0710); r.set_enable_instr = 1'b1;
    rt(r, 1'b1, 8'h0E, 32'h0000_0714);
    chk({mreq_ack_o, push_err_o, is_ext_o, if_o}, 4'hB);
    gt(1'b0); chk(if_o, 1'b0);
    r = base(32'h0000_0720); r.pop_flags_instr = 1'b1; r.flags_ld[FLAG_IF_BIT] = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(if_o, 1'b1);
    gt(1'b1); chk(if_o, 1'b1);
    r = base(32'h0000_0730); r.tswitch = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(if_o, 1'b0);
    r = base(32'h0000_0740); r.interrupt_return_instr = 1'b1; r.flags_ld[FLAG_IF_BIT] = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(if_o, 1'b1);
    r = base(32'h0000_0750); r.clear_enable_instr = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(if_o, 1'b0);
    r = base(32'h0000_0760); r.set_enable_instr = 1'b1; r.current_privilege_level = 2'h3;
    rt(r, 1'b1, VEC_GP, 32'h0000_0000); chk({push_err_o, if_o}, 2'h2);
    r = base(32'h0000_0770); r.set_enable_instr = 1'b1; r.current_privilege_level = 2'h1; r.io_privilege_level = 2'h1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(if_o, 1'b1);
    src(0, VEC_NMI);
    r = base(32'h0000_0800); r.rep_more = 1'b1;
    rt(r, 1'b1, VEC_NMI, 32'h0000_0800);
    chk({is_nmi_o, nmi_blk_o}, 2'h0);
    src(1, 8'h20);
    rt(base(32'h0000_0900), 1'b1, 8'h20, 32'h0000_0904);
    chk(lint_ack_o, 1'b1);
    src(1, 8'h05);
    rt(base(32'h0000_0910), 1'b0, 8'h00, 32'h0000_0000);
    chk(n_bad, 32'h0000_0001);
    r = base(32'h0000_0A00); r.clear_enable_instr = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000);
    src(2, 8'h00);
    rt(base(32'h0000_0A10), 1'b1, VEC_NMI, 32'h0000_0A14);
    chk({is_nmi_o, nmi_blk_o}, 2'h3);
    gt(1'b0);
    src(2, 8'h00);
    rt(base(32'h0000_0A20), 1'b0, 8'h00, 32'h0000_0000);
    r = base(32'h0000_0A30); r.interrupt_return_instr = 1'b1; r.vm86 = 1'b1; r.io_privilege_level = 2'h2;
    rt(r, 1'b1, VEC_GP, 32'h0000_0000); chk(nmi_blk_o, 1'b0);
    rt(base(32'h0000_0A40), 1'b1, VEC_NMI, 32'h0000_0A44);
    r = base(32'h0000_0A50); r.interrupt_return_instr = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(nmi_blk_o, 1'b0);
    src(3, 8'h00);
    rt(base(32'h0000_0A60), 1'b1, VEC_NMI, 32'h0000_0A64); chk(is_nmi_o, 1'b1);
    ahb(1'b0, OFF_LAST_IP, 32'h0000_0000); chk(rd, 32'h0000_0A64);
    ahb(1'b0, OFF_STATUS, 32'h0000_0000); chk(rd[ST_NMI_BLK], 1'b1);
    r = base(32'h0000_0A70); r.set_enable_instr = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000); chk(if_o, 1'b1);
    @(posedge sys_clk_i);
    ce <= 1'b0;
    r = base(32'h0000_0B00);
    r.fault = 1'b1;
    rt(r, 1'b0, 8'h00, 32'h0000_0000);
    @(posedge sys_clk_i);
    ce <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk({take_o, rollback_o}, 2'h0);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    chk({if_o, nmi_blk_o}, 2'h0);
    print_verdict;
  end
endmodule
